// file: hdl/pdm_div_cnt.sv
// step counter that divides a pulse stream by a programmable ratio
`timescale 1ns/1ps
module pdm_div_cnt #(
    parameter int RW = 6
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic hold_i,
    input wire logic step_i,
    input wire logic [RW-1:0] ratio_i,
    output logic last_o,
    output logic wrap_o
);

    // ==========================================================
    // counter
    logic [RW-1:0] cnt_reg;

    assign last_o = (cnt_reg >= ratio_i - RW'(1));
    assign wrap_o = step_i & last_o;

    always_ff @(posedge core_clk_i) begin
        if (reset_i || hold_i) begin
            cnt_reg <= '0;
        end else if (wrap_o) begin
            cnt_reg <= '0;
        end else if (step_i) begin
            cnt_reg <= cnt_reg + RW'(1);
        end
    end

endmodule : pdm_div_cnt

// file: hdl/pdm_loop_ctrl.sv
// divider, mode selection and lock logic around the system loop
// Operation
// - the post divider divides the oscillator clock by twice P, giving a 50% duty output.
// - the feedback divider makes output over input frequency equal to the multiplier field plus one.
// - in normal mode the post divider is used, so output equals M times input and oscillator over 2P.
// - in direct oscillator mode the oscillator clock drives the output with no post division.
// - in power-down without bypass the oscillator and phase detector stop, dividers are held in reset, lock stays low.
// - after power-down is released the loop runs again and lock rises only once regained.
// - the feedback output is a mask on the feedback input clock and stays high when M is one.
// - in direct bypass the analog part is off, the post divider idle, input passes to the output.
// - in direct bypass with M above one the feedback output runs at input frequency over M.
// - with direct clear the post divider divides by 2, 4, 8 or 16; direct set without bypass routes the oscillator out.
// - lock rises after more than eight good phase checks in a row and drops on one bad check.
`timescale 1ns/1ps
module pdm_loop_ctrl (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire pdm_pkg::pdm_ctrl_t loop_ctrl_word_i,
    input wire logic ref_clk_lvl_i,
    input wire logic osc_clk_lvl_i,
    input wire logic phase_ok_i,
    output logic analog_run_o,
    output logic loop_out_clock_o,
    output logic fb_mask_o,
    output logic lock_o,
    output pdm_pkg::pdm_state_t state_o
);

    // ==========================================================
    // helpers
    function automatic logic [pdm_pkg::RATIO_W-1:0] post_ratio(input logic [pdm_pkg::PSEL_W-1:0] sel);
        post_ratio = pdm_pkg::RATIO_ONE << sel;
    endfunction : post_ratio

    function automatic logic [pdm_pkg::RATIO_W-1:0] fb_ratio(input logic [pdm_pkg::FB_MULT_SELECT_W-1:0] sel);
        fb_ratio = {1'b0, sel} + pdm_pkg::RATIO_ONE;
    endfunction : fb_ratio

    // ==========================================================
    // mode decode
    logic pd_w;
    logic byp_w;
    logic dir_w;
    logic analog_on_w;
    logic div_hold_w;

    assign pd_w = loop_ctrl_word_i.loop_powerdown;
    assign byp_w = loop_ctrl_word_i.bypass;
    assign dir_w = loop_ctrl_word_i.direct;
    assign analog_on_w = !pd_w && !byp_w;
    assign div_hold_w = pd_w && !byp_w;

    // ==========================================================
    // edge detection on the clock levels
    logic ref_prev_reg;
    logic osc_prev_reg;
    logic ref_rise_w;
    logic osc_edge_w;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            ref_prev_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
        end else begin
            ref_prev_reg <= ref_clk_lvl_i;
            osc_prev_reg <= osc_clk_lvl_i;
        end
    end

    assign ref_rise_w = ref_clk_lvl_i && !ref_prev_reg;
    assign osc_edge_w = osc_clk_lvl_i && !osc_prev_reg;

    // ==========================================================
    // post divider, toggles every P source edges
    logic pdiv_reg;
    logic pdiv_step_w;
    logic pdiv_wrap_w;

    assign pdiv_step_w = byp_w ? ref_rise_w : (analog_on_w && osc_edge_w);

    pdm_div_cnt #(
        .RW(pdm_pkg::RATIO_W)
    ) u_post_div (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .hold_i(div_hold_w || (byp_w && dir_w)),
        .step_i(pdiv_step_w),
        .ratio_i(post_ratio(loop_ctrl_word_i.psel)),
        .last_o(),
        .wrap_o(pdiv_wrap_w)
    );

    always_ff @(posedge core_clk_i) begin
        if (reset_i || div_hold_w || (byp_w && dir_w)) begin
            pdiv_reg <= 1'b0;
        end else if (pdiv_wrap_w) begin
            pdiv_reg <= !pdiv_reg;
        end
    end

    // ==========================================================
    // output clock selection
    logic out_clk_next;
    logic out_clk_reg;
    logic out_rise_w;

    always_comb begin
        case ({pd_w, byp_w, dir_w})
            3'b000: out_clk_next = pdiv_reg;
            3'b001: out_clk_next = osc_clk_lvl_i;
            3'b010, 3'b110: out_clk_next = pdiv_reg;
            3'b011, 3'b111: out_clk_next = ref_clk_lvl_i;
            default: out_clk_next = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            out_clk_reg <= 1'b0;
        end else begin
            out_clk_reg <= out_clk_next;
        end
    end

    assign out_rise_w = out_clk_next && !out_clk_reg;

    // ==========================================================
    // feedback divider, mask on its input clock
    logic fb_last_w;
    logic fb_mask_reg;
    logic m_is_one_w;

    assign m_is_one_w = (loop_ctrl_word_i.fb_mult_select == '0);

    pdm_div_cnt #(
        .RW(pdm_pkg::RATIO_W)
    ) u_fb_div (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .hold_i(div_hold_w),
        .step_i(out_rise_w),
        .ratio_i(fb_ratio(loop_ctrl_word_i.fb_mult_select)),
        .last_o(fb_last_w),
        .wrap_o()
    );

    always_ff @(posedge core_clk_i) begin
        if (reset_i || div_hold_w) begin
            fb_mask_reg <= 1'b0;
        end else if (m_is_one_w) begin
            fb_mask_reg <= 1'b1;
        end else begin
            fb_mask_reg <= fb_last_w;
        end
    end

    // ==========================================================
    // lock detector
    logic [3:0] lock_cnt_reg;

    always_ff @(posedge core_clk_i) begin
        if (reset_i || !analog_on_w) begin
            lock_cnt_reg <= pdm_pkg::LOCK_CNT_RST;
        end else if (ref_rise_w) begin
            if (!phase_ok_i) begin
                lock_cnt_reg <= pdm_pkg::LOCK_CNT_RST;
            end else if (lock_cnt_reg <= pdm_pkg::LOCK_RUN) begin
                lock_cnt_reg <= lock_cnt_reg + 4'h1;
            end
        end
    end

    // ==========================================================
    // loop state
    pdm_pkg::pdm_state_t state_reg;
    pdm_pkg::pdm_state_t state_next;

    always_comb begin
        case (state_reg)
            pdm_pkg::ST_DOWN: state_next = pdm_pkg::ST_ACQ;
            pdm_pkg::ST_ACQ: state_next = (lock_cnt_reg > pdm_pkg::LOCK_RUN) ? pdm_pkg::ST_LOCK : pdm_pkg::ST_ACQ;
            pdm_pkg::ST_LOCK: state_next = (lock_cnt_reg > pdm_pkg::LOCK_RUN) ? pdm_pkg::ST_LOCK : pdm_pkg::ST_ACQ;
            pdm_pkg::ST_BYP: state_next = pdm_pkg::ST_DOWN;
            default: state_next = pdm_pkg::ST_DOWN;
        endcase
        if (byp_w) begin
            state_next = pdm_pkg::ST_BYP;
        end else if (pd_w) begin
            state_next = pdm_pkg::ST_DOWN;
        end else if (ref_rise_w && !phase_ok_i) begin
            state_next = pdm_pkg::ST_ACQ;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state_reg <= pdm_pkg::ST_DOWN;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // registered outputs
    logic analog_run_reg;
    logic lock_reg;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            analog_run_reg <= 1'b0;
            lock_reg <= 1'b0;
        end else begin
            analog_run_reg <= analog_on_w;
            lock_reg <= (state_next == pdm_pkg::ST_LOCK);
        end
    end

    assign analog_run_o = analog_run_reg;
    assign loop_out_clock_o = out_clk_reg;
    assign fb_mask_o = fb_mask_reg;
    assign lock_o = lock_reg;
    assign state_o = state_reg;

endmodule : pdm_loop_ctrl

// file: shared/pdm_pkg.sv
// shared constants and types for the loop divider and mode control
package pdm_pkg;

    // ==========================================================
    // field widths
    localparam int PSEL_W = 2;
    localparam int FB_MULT_SELECT_W = 5;
    localparam int RATIO_W = 6;

    // ==========================================================
    // lock detector figures
    localparam logic [3:0] LOCK_RUN = 4'h8;
    localparam logic [3:0] LOCK_CNT_RST = 4'h0;

    // ==========================================================
    // reset values of configuration and outputs
    localparam logic [PSEL_W-1:0] PSEL_DIV2 = 2'h0;
    localparam logic [RATIO_W-1:0] RATIO_ONE = 6'h01;
    localparam logic [RATIO_W-1:0] CNT_RST = 6'h00;

    // ==========================================================
    // loop control word
    typedef struct packed {
        logic loop_powerdown;
        logic bypass;
        logic direct;
        logic [PSEL_W-1:0] psel;
        logic [FB_MULT_SELECT_W-1:0] fb_mult_select;
    } pdm_ctrl_t;

    // ==========================================================
    // loop state, gray along down -> acquire -> locked
    typedef enum logic [1:0] {
        ST_DOWN = 2'b00,
        ST_ACQ = 2'b01,
        ST_LOCK = 2'b11,
        ST_BYP = 2'b10
    } pdm_state_t;

endpackage : pdm_pkg

// file: tb/pdm_loop_ctrl_chk.sv
// port checker for the loop divider and mode control
`timescale 1ns/1ps
module pdm_loop_ctrl_chk (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire pdm_pkg::pdm_ctrl_t loop_ctrl_word_i,
    input wire logic ref_clk_lvl_i,
    input wire logic osc_clk_lvl_i,
    input wire logic phase_ok_i,
    input wire logic analog_run_o,
    input wire logic loop_out_clock_o,
    input wire logic fb_mask_o,
    input wire logic lock_o,
    input wire pdm_pkg::pdm_state_t state_o
);
    // ==========================================================
    // run length of good ref checks
    logic ref_last_reg;
    logic [3:0] good_reg;
    logic off_w;
    logic pd_w;
    logic rise_w;
    logic byp_w;
    assign byp_w = loop_ctrl_word_i.bypass;
    assign pd_w = loop_ctrl_word_i.loop_powerdown && !byp_w;
    assign off_w = loop_ctrl_word_i.loop_powerdown || byp_w;
    assign rise_w = ref_clk_lvl_i && !ref_last_reg;
    always_ff @(posedge core_clk_i) begin
        ref_last_reg <= !reset_i && ref_clk_lvl_i;
        if (reset_i || off_w || (rise_w && !phase_ok_i)) begin
            good_reg <= 4'h0;
        end else if (rise_w && good_reg != 4'hf) begin
            good_reg <= good_reg + 4'h1;
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    pd_quiet_a: assert property (pd_w |=> !(analog_run_o || lock_o || loop_out_clock_o || fb_mask_o))
        else $error("active in power-down");
    byp_off_a: assert property (byp_w |=> !analog_run_o)
        else $error("analog on in bypass");
    osc_pass_a: assert property (!off_w && loop_ctrl_word_i.direct |=> loop_out_clock_o == $past(osc_clk_lvl_i))
        else $error("osc not passed");
    ref_pass_a: assert property (byp_w && loop_ctrl_word_i.direct |=> loop_out_clock_o == $past(ref_clk_lvl_i))
        else $error("ref not passed");
    mask_one_a: assert property ((loop_ctrl_word_i.fb_mult_select == 5'h00 && !pd_w) [*3] |-> fb_mask_o)
        else $error("mask low with M one");
    lock_rise_a: assert property ($rose(lock_o) |-> good_reg >= 4'h9)
        else $error("lock too early");
    lock_drop_a: assert property (lock_o && rise_w && !phase_ok_i |=> !lock_o)
        else $error("lock kept after bad check");
    lock_state_a: assert property (lock_o |-> state_o == pdm_pkg::ST_LOCK && !$past(off_w))
        else $error("lock without running");
endmodule : pdm_loop_ctrl_chk

bind pdm_loop_ctrl pdm_loop_ctrl_chk i_pdm_loop_ctrl_chk (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .loop_ctrl_word_i(loop_ctrl_word_i), .ref_clk_lvl_i(ref_clk_lvl_i), .osc_clk_lvl_i(osc_clk_lvl_i),
    .phase_ok_i(phase_ok_i), .analog_run_o(analog_run_o), .loop_out_clock_o(loop_out_clock_o),
    .fb_mask_o(fb_mask_o), .lock_o(lock_o), .state_o(state_o));

// file: tb/pdm_loop_ctrl_test.sv
// self-checking bench for the loop divider and mode control
`timescale 1ns/1ps
module pdm_loop_ctrl_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req = 1'b0;
    logic ref_l = 1'b0;
    logic osc_l = 1'b0;
    logic ok = 1'b0;
    logic [1:0] ref_div = 2'h0;
    pdm_pkg::pdm_ctrl_t tgt = '0;
    pdm_pkg::pdm_ctrl_t ctrl;
    pdm_pkg::pdm_state_t st;
    logic run, out, mask, lock, r, g, prev;
    int fails = 0;
    int check_count = 0;
    int m;
    int good;
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        osc_l <= ~osc_l;
        ref_div <= ref_div + 2'h1;
        ref_l <= ref_div[1];
    end
    pdm_sw_model i_pdm_sw_model (.core_clk_i(clk), .reset_i(rst), .req_i(req), .target_i(tgt), .ctrl_o(ctrl));
    pdm_loop_ctrl i_pdm_loop_ctrl (.core_clk_i(clk), .reset_i(rst), .loop_ctrl_word_i(ctrl), .ref_clk_lvl_i(ref_l),
        .osc_clk_lvl_i(osc_l), .phase_ok_i(ok), .analog_run_o(run), .loop_out_clock_o(out), .fb_mask_o(mask),
        .lock_o(lock), .state_o(st));
    task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s exp %0d seen %0d", n, exp, seen);
        end
    endtask : chk
    task automatic report_and_stop();
        if (fails == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic step();
        @(posedge clk);
        #1;
    endtask : step
    task automatic apply(input pdm_pkg::pdm_ctrl_t c, input int w);
        @(posedge clk);
        tgt <= c;
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        repeat (w) step();
    endtask : apply
    // cycles between two rising edges of out or mask
    task automatic period(input string n, input bit sel, input int exp);
        int k;
        k = 0;
        for (int t = 0; t < 4; t++) begin
            do begin
                step();
                k++;
            end while ((sel ? mask : out) !== t[0] && k < 3000);
            if (t == 1) k = 0;
        end
        chk(n, k[15:0], exp[15:0]);
    endtask : period
    initial begin
        m = $urandom(88184);
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int p = 0; p < 4; p++) begin
            m = 2 + $urandom % 3;
            apply({3'h0, p[1:0], 5'(m - 1)}, 20);
            period("norm out", 1'b0, 4 << p);
            period("norm mask", 1'b1, m * (4 << p));
            apply({1'($urandom), 2'h2, p[1:0], 5'(m - 1)}, 20);
            period("byp out", 1'b0, 8 << p);
            period("byp mask", 1'b1, m * (8 << p));
        end
        apply({3'h1, 2'h0, 5'h02}, 20);
        period("dosc out", 1'b0, 2);
        period("dosc mask", 1'b1, 6);
        apply({3'h3, 2'h2, 5'h03}, 20);
        period("dbyp out", 1'b0, 4);
        period("dbyp mask", 1'b1, 16);
        chk("dbyp run", run, 16'h0);
        chk("dbyp state", 16'(st), 16'(pdm_pkg::ST_BYP));
        apply({3'h2, 2'h1, 5'h00}, 20);
        repeat (8) begin
            step();
            chk("mask one", mask, 16'h1);
        end
        apply({3'h0, 2'h0, 5'h01}, 1);
        good = 0;
        prev = ref_l;
        for (int i = 0; i < 140; i++) begin
            r = ref_l;
            g = ok;
            @(posedge clk);
            ok <= !(i < 8 || (i >= 70 && i < 74));
            #1;
            if (r && !prev && !g) begin
                good = 0;
            end
            chk("lock", lock, 16'(good >= 9));
            if (r && !prev && g) begin
                good++;
            end
            prev = r;
        end
        apply({3'h4, 2'h0, 5'h01}, 20);
        chk("pd outs", {run, out, mask, lock}, 16'h0);
        chk("pd state", 16'(st), 16'(pdm_pkg::ST_DOWN));
        report_and_stop();
    end
    initial begin
        #750000;
        fails++;
        report_and_stop();
    end
endmodule : pdm_loop_ctrl_test

// file: tb/pdm_sw_model.sv
// software model that reprograms the loop through power-down
`timescale 1ns/1ps
module pdm_sw_model (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic req_i,
    input wire pdm_pkg::pdm_ctrl_t target_i,
    output pdm_pkg::pdm_ctrl_t ctrl_o
);
    logic [1:0] step_reg;
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            ctrl_o <= '0;
            step_reg <= 2'h0;
        end else if (req_i || step_reg != 2'h0) begin
            if (step_reg != 2'h0) ctrl_o <= target_i;
            if (step_reg != 2'h2) ctrl_o.loop_powerdown <= 1'b1;
            step_reg <= (step_reg == 2'h2) ? 2'h0 : step_reg + 2'h1;
        end
    end
endmodule : pdm_sw_model
